// [asfe_map.vh]
// Constants for the angle sensor SPI frame engine
`ifndef ASFE_MAP_VH
`define ASFE_MAP_VH
`define ASFE_LEN_STD      5'h10
`define ASFE_LEN_DELAY    5'h11
`define ASFE_LEN_CRC      5'h14
`define ASFE_LEN_SHARED   5'h15
`define ASFE_CRC_PRESET   4'hF
`define ASFE_ADDR_W       6
`define ASFE_RW_BIT       14
`define ASFE_LEAD_BIT     15
`define ASFE_ADDR_HI      13
`define ASFE_ADDR_LO      8
`define ASFE_ZERO_ADDR    6'h00
`define ASFE_ZERO_DATA    16'h0000
`define ASFE_ZERO_BYTE    8'h00
`endif

// [asfe_crc4.v]
// Serial-to-parallel 4-bit CRC (x^4+x+1) over a 16-bit word, MSB first
`timescale 1ns/10ps
`include "asfe_map.vh"
module asfe_crc4
(
    // Data in
    input  wire [15:0] i_data,
    // CRC out
    output reg  [3:0]  o_crc
);
    integer k;
    reg     inv;
    reg     [3:0] c;
    always @*
    begin
        inv = 1'b0;
        c   = `ASFE_CRC_PRESET;
        for (k = 15; k >= 0; k = k - 1)
        begin
            inv = i_data[k] ^ c[3];
            c   = {c[2], c[1], c[0] ^ inv, inv};
        end
        o_crc = c;
    end
endmodule

// [asfe_spi_engine.v]
// SPI frame engine of an angle sensor, oversampling the host serial clock
//
// How it works
// - Mode 3: clock idles high, data sampled on rising edge.
// - Frames of 16, 20 or 21 clocked bits are standard.
// - A 20-bit frame is 16 payload bits then four CRC bits.
// - A 17-bit frame is legal only with the seventeen-bit enable set.
// - More clocks than the expected frame length sets the overrun warning.
// - No warning for clean 16, 20, or enabled 17-bit frames.
// - In 17-bit frames the sixteenth output bit holds until the seventeenth fall.
// - In 21-bit frames the device repeats the top CRC bit last.
// - MOSI is captured on each rising serial clock edge.
// - MISO changes after each falling edge but the first, valid before next rise.
// - A read result is returned in the following frame.
// - A new read may be sent while the previous result shifts out.
// - All-zero command reads address 0 harmlessly and returns 0x0000.
// - Even-address read returns the even byte high, odd byte low.
// - Odd-address read returns that byte low, upper eight bits zero.
// - Output CRC: x^4+x+1, preset ones, MSB first, sent C3 to C0.
// - With CRC check enabled, bad-CRC frames are dropped and flagged.
`timescale 1ns/10ps
`include "asfe_map.vh"
module asfe_spi_engine
#(
    parameter CNT_W = 5
)
(
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // SPI pins
    input  wire        i_sclk,
    input  wire        i_chip_select_n,
    input  wire        i_mosi,
    output reg         o_miso,
    output reg         o_miso_oe,
    // Configuration
    input  wire        i_seventeen_bit_frame_enable,
    input  wire        i_incoming_crc_check_enable,
    // Register file access
    output reg  [5:0]  o_rd_addr,
    input  wire [7:0]  i_rd_even,
    input  wire [7:0]  i_rd_odd,
    output reg         o_wr_en,
    output reg  [5:0]  o_wr_addr,
    output reg  [7:0]  o_wr_data,
    // Status
    output reg         o_clock_overrun_warning,
    input  wire        i_clock_overrun_clear,
    output reg         o_crc_error,
    input  wire        i_crc_error_clear
);
    // Pin filters: a new level counts once stages two and three agree
    localparam PIN_SCLK = 0;
    localparam PIN_CS   = 1;
    localparam PIN_MOSI = 2;
    localparam PIN_N    = 3;
    // Clock and select idle high, data idles low
    localparam [PIN_N-1:0] PIN_IDLE = 3'h3;
    wire [PIN_N-1:0] pin_raw = {i_mosi, i_chip_select_n, i_sclk};
    wire [PIN_N-1:0] pin_level;
    wire [PIN_N-1:0] pin_take;
    genvar g;
    generate
        for (g = 0; g < PIN_N; g = g + 1)
        begin : g_pin
            reg [2:0] sync;
            reg       held;
            always @(posedge i_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    sync <= {3{PIN_IDLE[g]}};
                    held <= PIN_IDLE[g];
                end
                else
                begin
                    sync <= {sync[1:0], pin_raw[g]};
                    if (pin_take[g])
                        held <= sync[2];
                end
            end
            // Stage one feeds stage two only, never the logic
            assign pin_take[g]  = (sync[1] == sync[2]) & (sync[2] != held);
            assign pin_level[g] = held;
        end
    endgenerate

    // Reset levels equal the idle levels, so no false edge follows reset
    wire sclk_rise = pin_take[PIN_SCLK] & ~pin_level[PIN_SCLK];
    wire sclk_fall = pin_take[PIN_SCLK] & pin_level[PIN_SCLK];
    wire cs_low    = ~pin_level[PIN_CS];
    wire cs_rise   = pin_take[PIN_CS] & ~pin_level[PIN_CS];
    // MOSI has settled long before the rising edge is seen
    wire mosi_bit  = pin_level[PIN_MOSI];

    reg [CNT_W-1:0] bit_cnt;
    reg [CNT_W-1:0] fall_cnt;
    reg [20:0]      rx_shift;
    reg [15:0]      tx_word;
    reg [3:0]       tx_crc;
    reg             pend_read;
    reg [5:0]       pend_addr;

    wire [3:0] rx_crc_calc;
    wire [3:0] tx_crc_calc;
    reg  [15:0] resp_word;

    // Payload of a 20- or 21-bit frame sits in different positions
    wire [15:0] rx_pay20 = rx_shift[19:4];
    wire [3:0]  rx_c20   = rx_shift[3:0];
    wire [15:0] rx_pay21 = rx_shift[20:5];
    wire [3:0]  rx_c21   = rx_shift[4:1];
    wire [15:0] rx_pay16 = rx_shift[15:0];
    wire [15:0] rx_pay17 = rx_shift[16:1];

    reg  [15:0] cmd;
    reg         len_ok;
    reg         has_crc;
    reg  [3:0]  crc_in;
    always @*
    begin
        cmd     = rx_pay16;
        len_ok  = 1'b1;
        has_crc = 1'b0;
        crc_in  = rx_c20;
        case (bit_cnt)
            `ASFE_LEN_STD:
                cmd = rx_pay16;
            `ASFE_LEN_DELAY:
            begin
                cmd    = rx_pay17;
                len_ok = i_seventeen_bit_frame_enable;
            end
            `ASFE_LEN_CRC:
            begin
                cmd     = rx_pay20;
                has_crc = 1'b1;
            end
            `ASFE_LEN_SHARED:
            begin
                cmd     = rx_pay21;
                has_crc = 1'b1;
                crc_in  = rx_c21;
            end
            default:
                len_ok = 1'b0;
        endcase
    end

    asfe_crc4 u_rx_crc
    (
        .i_data (cmd),
        .o_crc  (rx_crc_calc)
    );

    asfe_crc4 u_tx_crc
    (
        .i_data (resp_word),
        .o_crc  (tx_crc_calc)
    );

    wire crc_bad = has_crc & i_incoming_crc_check_enable & (crc_in != rx_crc_calc);
    wire is_write = cmd[`ASFE_RW_BIT];
    wire [5:0] cmd_addr = cmd[`ASFE_ADDR_HI:`ASFE_ADDR_LO];
    wire frame_ok = len_ok & ~crc_bad & ~cmd[`ASFE_LEAD_BIT];

    // Odd addresses zero the top byte; address zero reads as zero
    always @*
    begin
        if (pend_addr == `ASFE_ZERO_ADDR)
            resp_word = `ASFE_ZERO_DATA;
        else if (pend_addr[0])
            resp_word = {`ASFE_ZERO_BYTE, i_rd_odd};
        else
            resp_word = {i_rd_even, i_rd_odd};
    end

    // Output bit index: 0..15 data, 16..19 CRC, 20 repeats C3
    reg out_bit;
    always @*
    begin
        if (fall_cnt < `ASFE_LEN_STD)
            out_bit = tx_word[15 - fall_cnt[3:0]];
        else if (fall_cnt < `ASFE_LEN_CRC)
            out_bit = tx_crc[3 - fall_cnt[1:0]];
        else
            out_bit = tx_crc[3];
    end

    // Every length but the accepted ones warns, short frames included
    wire len_warn = ~len_ok;

    // Receive side: bit count and MOSI shift register
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bit_cnt  <= {CNT_W{1'b0}};
            rx_shift <= 21'h00_0000;
        end
        else if (!cs_low)
        begin
            bit_cnt <= {CNT_W{1'b0}};
        end
        else if (sclk_rise)
        begin
            rx_shift <= {rx_shift[19:0], mosi_bit};
            // Saturate so a runaway clock still reads as too long
            if (bit_cnt != {CNT_W{1'b1}})
                bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // Transmit side: response latched while idle, one bit per falling edge after the first
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            fall_cnt  <= {CNT_W{1'b0}};
            tx_word   <= `ASFE_ZERO_DATA;
            tx_crc    <= `ASFE_CRC_PRESET;
            o_miso    <= 1'b0;
            o_miso_oe <= 1'b0;
        end
        else if (!cs_low)
        begin
            fall_cnt  <= {CNT_W{1'b0}};
            o_miso_oe <= 1'b0;
            // Latch while idle so the read path has settled by the frame
            tx_word   <= pend_read ? resp_word : `ASFE_ZERO_DATA;
            tx_crc    <= pend_read ? tx_crc_calc : `ASFE_CRC_PRESET;
        end
        else
        begin
            o_miso_oe <= 1'b1;
            // The first fall keeps bit 15; later falls advance the index
            if (sclk_fall && bit_cnt != {CNT_W{1'b0}} && fall_cnt != {CNT_W{1'b1}})
                fall_cnt <= fall_cnt + 1'b1;
            // Follows the index a clock late, well after the pin edge
            o_miso    <= out_bit;
        end
    end

    // Sticky flags: an event at the frame end wins over a clear
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_clock_overrun_warning <= 1'b0;
            o_crc_error             <= 1'b0;
        end
        else
        begin
            if (cs_rise && len_warn)
                o_clock_overrun_warning <= 1'b1;
            else if (i_clock_overrun_clear)
                o_clock_overrun_warning <= 1'b0;
            if (cs_rise && crc_bad && len_ok)
                o_crc_error <= 1'b1;
            else if (i_crc_error_clear)
                o_crc_error <= 1'b0;
        end
    end

    // Command decode at the frame end; a read answers in the next frame
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pend_read <= 1'b0;
            pend_addr <= `ASFE_ZERO_ADDR;
            o_rd_addr <= `ASFE_ZERO_ADDR;
            o_wr_en   <= 1'b0;
            o_wr_addr <= `ASFE_ZERO_ADDR;
            o_wr_data <= `ASFE_ZERO_BYTE;
        end
        else
        begin
            o_wr_en   <= 1'b0;
            o_rd_addr <= pend_addr;
            if (cs_rise)
            begin
                // A refused frame also drops the read it would have answered
                pend_read <= 1'b0;
                if (frame_ok && is_write)
                begin
                    o_wr_en   <= 1'b1;
                    o_wr_addr <= cmd_addr;
                    o_wr_data <= cmd[7:0];
                end
                else if (frame_ok)
                begin
                    pend_read <= 1'b1;
                    pend_addr <= cmd_addr;
                end
            end
        end
    end
endmodule

// [asfe_spi_engine_sva.sv]
// Port checker for the SPI frame engine
`timescale 1ns/10ps
module asfe_spi_engine_sva
(
    // Clock, reset and pins
    input wire i_clk,
    input wire i_rst,
    input wire i_sclk,
    input wire i_chip_select_n,
    input wire o_miso,
    input wire o_miso_oe,
    // Events and flags
    input wire o_wr_en,
    input wire o_clock_overrun_warning,
    input wire i_clock_overrun_clear,
    input wire o_crc_error
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_oe_off; i_chip_select_n [*7] |-> !o_miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven while idle");
    property p_oe_on; !i_chip_select_n [*7] |-> o_miso_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");
    property p_wr_one; o_wr_en |=> !o_wr_en; endproperty
    a_wr_one: assert property (p_wr_one) else $error("write pulse too long");
    property p_wr_end; o_wr_en |-> i_chip_select_n; endproperty
    a_wr_end: assert property (p_wr_end) else $error("write inside frame");
    // Bit 15 loads as the output turns on, so only later changes need a clock fall
    property p_miso_fall;
        o_miso_oe && $past(o_miso_oe, 2) && $changed(o_miso) |-> !$past(i_sclk, 2)
            || !$past(i_sclk, 3) || !$past(i_sclk, 4) || !$past(i_sclk, 5);
    endproperty
    a_miso_fall: assert property (p_miso_fall) else $error("miso moved off fall");
    property p_ovr_set; $rose(o_clock_overrun_warning) |-> i_chip_select_n; endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun set mid frame");
    property p_ovr_keep;
        o_clock_overrun_warning && !i_clock_overrun_clear |=> o_clock_overrun_warning;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost");
    property p_crc_set; $rose(o_crc_error) |-> i_chip_select_n; endproperty
    a_crc_set: assert property (p_crc_set) else $error("crc flag mid frame");
    c_wr: cover property (o_wr_en);
    c_ovr: cover property ($rose(o_clock_overrun_warning));
    c_crc: cover property ($rose(o_crc_error));
endmodule
bind asfe_spi_engine asfe_spi_engine_sva chk_u (.i_clk, .i_rst, .i_sclk, .i_chip_select_n,
    .o_miso, .o_miso_oe, .o_wr_en, .o_clock_overrun_warning, .i_clock_overrun_clear,
    .o_crc_error);

// [asfe_host_model.sv]
// Host controller model sending mode 3 frames
`timescale 1ns/10ps
module asfe_host_model
(
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input  wire  i_miso
);
    initial
    begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // Words are left aligned: bit 20 goes first, r mirrors w
    task xfer(input int n, input logic [20:0] w, output logic [20:0] r);
        r = 21'h0;
        o_cs_n = 1'b0;
        #60;
        for (int i = 0; i < n; i++)
        begin
            o_sclk = 1'b0;
            o_mosi = w[20-i];
            #80;
            o_sclk = 1'b1;
            r[20-i] = i_miso;
            #80;
        end
        o_cs_n = 1'b1;
        // Released line must not keep its last bit
        o_mosi = ~o_mosi;
        #400;
    endtask
endmodule

// [asfe_spi_engine_tb_top.sv]
// Self-checking bench for the SPI frame engine
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module asfe_spi_engine_tb_top;
    logic        i_clk = 0;
    logic        i_rst = 1;
    logic        i_seventeen_bit_frame_enable = 0;
    logic        i_incoming_crc_check_enable = 0;
    logic        i_clock_overrun_clear = 0;
    logic        i_crc_error_clear = 0;
    wire         i_sclk, i_chip_select_n, i_mosi, o_miso, o_miso_oe, o_wr_en;
    wire         o_clock_overrun_warning, o_crc_error;
    wire  [5:0]  o_rd_addr, o_wr_addr;
    wire  [7:0]  o_wr_data;
    // Register pair pattern tells even from odd byte
    wire  [7:0]  i_rd_even = {2'b10, o_rd_addr[5:1], 1'b0};
    wire  [7:0]  i_rd_odd = {2'b01, o_rd_addr[5:1], 1'b1};
    logic [20:0] r;
    int          wr_count = 0;
    int          failures = 0;
    int          compares = 0;
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_wr_en) wr_count <= wr_count + 1;
    asfe_spi_engine dut_u
    (
        .i_clk                        (i_clk),
        .i_rst                        (i_rst),
        .i_sclk                       (i_sclk),
        .i_chip_select_n              (i_chip_select_n),
        .i_mosi                       (i_mosi),
        .o_miso                       (o_miso),
        .o_miso_oe                    (o_miso_oe),
        .i_seventeen_bit_frame_enable (i_seventeen_bit_frame_enable),
        .i_incoming_crc_check_enable  (i_incoming_crc_check_enable),
        .o_rd_addr                    (o_rd_addr),
        .i_rd_even                    (i_rd_even),
        .i_rd_odd                     (i_rd_odd),
        .o_wr_en                      (o_wr_en),
        .o_wr_addr                    (o_wr_addr),
        .o_wr_data                    (o_wr_data),
        .o_clock_overrun_warning      (o_clock_overrun_warning),
        .i_clock_overrun_clear        (i_clock_overrun_clear),
        .o_crc_error                  (o_crc_error),
        .i_crc_error_clear            (i_crc_error_clear)
    );
    asfe_host_model host_u (.o_sclk(i_sclk), .o_cs_n(i_chip_select_n), .o_mosi(i_mosi),
        .i_miso(o_miso_oe ? o_miso : ~o_miso));
    function automatic logic [3:0] crc4(input logic [15:0] d);
        logic [3:0] c;
        logic       v;
        c = 4'hF;
        for (int i = 15; i >= 0; i--)
        begin
            v = d[i] ^ c[3];
            c = {c[2:1], c[0] ^ v, v};
        end
        return c;
    endfunction
    task t_reads;
        logic [3:0] c;
        c = crc4(16'h0065);
        host_u.xfer(16, {16'h2400, 5'h00}, r);
        host_u.xfer(20, {16'h2500, crc4(16'h2500), 1'b0}, r);
        `CHK(r[20:1], {16'hA465, crc4(16'hA465)})
        host_u.xfer(21, 21'h0, r);
        `CHK(r, {16'h0065, c, c[3]})
        host_u.xfer(16, 21'h0, r);
        `CHK(r[20:5], 16'h0000)
        `CHK(o_clock_overrun_warning, 1'b0)
    endtask
    task t_len(input int n, input logic en, input logic x);
        @(negedge i_clk) i_seventeen_bit_frame_enable = en;
        host_u.xfer(n, 21'h0, r);
        `CHK(o_clock_overrun_warning, x)
        @(negedge i_clk) i_clock_overrun_clear = 1'b1;
        @(negedge i_clk) i_clock_overrun_clear = 1'b0;
    endtask
    task t_crc;
        int n;
        @(negedge i_clk) i_incoming_crc_check_enable = 1'b1;
        n = wr_count;
        host_u.xfer(20, {16'h45A5, ~crc4(16'h45A5), 1'b0}, r);
        `CHK({wr_count == n, o_crc_error}, 2'b11)
        host_u.xfer(20, {16'h4433, crc4(16'h4433), 1'b0}, r);
        `CHK({wr_count == n + 1, o_wr_addr, o_wr_data}, {1'b1, 6'h04, 8'h33})
        @(negedge i_clk) i_crc_error_clear = 1'b1;
        @(negedge i_clk) i_crc_error_clear = 1'b0;
        `CHK(o_crc_error, 1'b0)
    endtask
    task stop_test;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk) i_rst = 1'b0;
        repeat (8) @(negedge i_clk);
        host_u.xfer(16, {16'h45A5, 5'h00}, r);
        `CHK({wr_count == 1, o_wr_addr, o_wr_data}, {1'b1, 6'h05, 8'hA5})
        t_reads;
        t_len(17, 1'b0, 1'b1);
        t_len(17, 1'b1, 1'b0);
        t_len(18, 1'b1, 1'b1);
        t_crc;
        stop_test;
    end
    // Hang guard: a stuck run counts as a mismatch
    initial
    begin
        #200000;
        failures++;
        stop_test;
    end
endmodule
